// ===== hw/cpwm_consts.svh
// register offsets, field positions, reset values and timing counts of the compare/pwm unit
// Notes on behaviour
// - in compare mode, compare value is checked against timer one every cycle
// - every compare sub-mode sets the module interrupt flag on a match
// - mode 0010 toggles, 1000 sets, 1001 clears the pin; 0000 resets the module
// - writing zero to the control register forces the compare latch low
// - mode 1010 only raises the flag; pin left alone
// - mode 1011 resets timer one, starts a conversion if enabled; pin left alone
// - trigger asserts on match; timer one clears at its next tick
// - the trigger never sets the timer one overflow flag
// - if the match is gone by the next tick, timer one is not reset
// - clearing the control register releases the pin to the port
// - pwm period is (period + 1) x 4 clocks x prescale of 1, 4 or 16
// - after timer two equals period: clear it, load duty, set pin unless 0%
// - the timer two postscaler does not affect the pwm period
// - duty is 10 bits: duty low byte on top, control bits 5:4 below
// - duty writes land any time but take effect at the period end
// - active duty is an 8-bit shadow byte plus a 2-bit latch
// - time base is timer two plus clock phase or prescaler bits
// - pin goes low when the time base equals the active duty
// - a pulse width beyond the period leaves the pin unchanged
// - resolution is log2(4 x (period + 1)), 10 bits at period 255
// - in sleep timer two and module state freeze; pin holds its level
`ifndef CPWM_CONSTS_SVH
`define CPWM_CONSTS_SVH

`define CPWM_OFS_CTRL 8'h00
`define CPWM_OFS_CMPV 8'h04
`define CPWM_OFS_DUTYL 8'h08
`define CPWM_OFS_SHADH 8'h0C
`define CPWM_OFS_STAT 8'h10
`define CPWM_OFS_T1CNT 8'h14
`define CPWM_OFS_T2CNT 8'h18
`define CPWM_OFS_PERIOD 8'h1C
`define CPWM_OFS_T2CTL 8'h20
`define CPWM_OFS_AUX 8'h24

`define CPWM_STAT_IRQ 0
`define CPWM_STAT_T1OVF 1
`define CPWM_T2CTL_ON 2
`define CPWM_AUX_T1ON 0
`define CPWM_AUX_ADCEN 1

`define CPWM_RST_BYTE 8'h00
`define CPWM_RST_WORD 16'h0000
`define CPWM_RST_PERIOD 8'hFF
`define CPWM_T1_MAX 16'hFFFF
`define CPWM_PH_LAST 2'h3
`define CPWM_PS4_LAST 2'h3
`define CPWM_PS16_LAST 4'hF
`define CPWM_DUTY_ZERO 10'h000

`endif

// ===== hw/cpwm_pkg.sv
// types shared by the compare/pwm unit
package cpwm_pkg;

  // ordered by mode value along the usual off -> compare -> pwm path
  typedef enum logic [3:0] {
    CPWM_OFF = 4'h0,
    CPWM_TOGGLE = 4'h2,
    CPWM_SET = 4'h8,
    CPWM_CLEAR = 4'h9,
    CPWM_SOFTIRQ = 4'hA,
    CPWM_SPECIAL = 4'hB,
    CPWM_PWM = 4'hC
  } cpwm_mode_t;

  typedef struct packed {
    logic [1:0] steer;
    logic [1:0] fine;
    logic [3:0] mode;
  } cpwm_ctrl_t;

  typedef struct packed {
    logic [3:0] postscale;
    logic on;
    logic [1:0] prescale;
  } cpwm_t2ctl_t;

endpackage

// ===== hw/cpwm_unit.sv
// compare and standard pwm unit with timers one and two, apb register slave
`timescale 1ns/1ps
`default_nettype none
`include "cpwm_consts.svh"

module cpwm_unit (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_one_tick_i,
  input wire logic sleep_i,
  output logic module_output_pin_o,
  output logic module_pin_owned_o,
  output logic module_irq_flag_o,
  output logic special_event_o,
  output logic adc_start_o
);

  cpwm_pkg::cpwm_ctrl_t module_control_reg_r;
  cpwm_pkg::cpwm_t2ctl_t timer_two_control_r;
  logic [7:0] duty_low_reg_r;
  logic [7:0] duty_shadow_high_r;
  logic [1:0] fine_latch_r;
  logic [15:0] timer_one_count_r;
  logic [7:0] timer_two_count_r;
  logic [7:0] pwm_period_reg_r;
  logic [1:0] phase_r;
  logic [3:0] presc_r;
  logic [1:0] aux_r;
  logic module_irq_flag_r;
  logic timer_one_overflow_flag_r;
  logic cmp_latch_r;
  logic pwm_out_r;
  logic match_d_r;
  logic [31:0] prdata_r;

  logic [3:0] mode;
  logic known;
  logic setup;
  logic wr;
  logic run;
  logic match;
  logic cmp_evt;
  logic t1_tick;
  logic t2_tick;
  logic period_end;
  logic [1:0] tb_low;
  logic [9:0] time_base;
  logic [9:0] duty_act;
  logic is_pwm_mode;
  logic is_cmp_mode;

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = (m[3:2] == 2'h3);
  endfunction

  function automatic logic is_cmp(input logic [3:0] m);
    is_cmp = (m == cpwm_pkg::CPWM_TOGGLE) || (m == cpwm_pkg::CPWM_SET)
      || (m == cpwm_pkg::CPWM_CLEAR) || (m == cpwm_pkg::CPWM_SOFTIRQ)
      || (m == cpwm_pkg::CPWM_SPECIAL);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign mode = module_control_reg_r.mode;
  assign is_pwm_mode = is_pwm(mode);
  assign is_cmp_mode = is_cmp(mode);
  assign run = !sleep_i;

  // apb decode; zero wait states, read data captured in the setup phase
  always_comb
  begin
    known = hit(paddr, `CPWM_OFS_CTRL) || hit(paddr, `CPWM_OFS_CMPV)
      || hit(paddr, `CPWM_OFS_DUTYL) || hit(paddr, `CPWM_OFS_SHADH)
      || hit(paddr, `CPWM_OFS_STAT) || hit(paddr, `CPWM_OFS_T1CNT)
      || hit(paddr, `CPWM_OFS_T2CNT) || hit(paddr, `CPWM_OFS_PERIOD)
      || hit(paddr, `CPWM_OFS_T2CTL) || hit(paddr, `CPWM_OFS_AUX);
  end

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && known;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known;
  assign prdata = prdata_r;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prdata_r <= 32'h0000_0000;
    else if (setup && !pwrite)
    begin
      case (paddr)
        `CPWM_OFS_CTRL: prdata_r <= {24'h00_0000, module_control_reg_r};
        `CPWM_OFS_CMPV: prdata_r <= {16'h0000, duty_shadow_high_r, duty_low_reg_r};
        `CPWM_OFS_DUTYL: prdata_r <= {24'h00_0000, duty_low_reg_r};
        `CPWM_OFS_SHADH: prdata_r <= {24'h00_0000, duty_shadow_high_r};
        `CPWM_OFS_STAT: prdata_r <= {30'h0000_0000, timer_one_overflow_flag_r,
          module_irq_flag_r};
        `CPWM_OFS_T1CNT: prdata_r <= {16'h0000, timer_one_count_r};
        `CPWM_OFS_T2CNT: prdata_r <= {24'h00_0000, timer_two_count_r};
        `CPWM_OFS_PERIOD: prdata_r <= {24'h00_0000, pwm_period_reg_r};
        `CPWM_OFS_T2CTL: prdata_r <= {25'h000_0000, timer_two_control_r};
        `CPWM_OFS_AUX: prdata_r <= {30'h0000_0000, aux_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // control, timer two control, period and aux registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      module_control_reg_r <= `CPWM_RST_BYTE;
      timer_two_control_r <= 7'h00;
      pwm_period_reg_r <= `CPWM_RST_PERIOD;
      aux_r <= 2'h0;
    end
    else if (wr)
    begin
      case (paddr)
        `CPWM_OFS_CTRL: module_control_reg_r <= pwdata[7:0];
        `CPWM_OFS_T2CTL: timer_two_control_r <= pwdata[6:0];
        `CPWM_OFS_PERIOD: pwm_period_reg_r <= pwdata[7:0];
        `CPWM_OFS_AUX: aux_r <= pwdata[1:0];
        default: aux_r <= aux_r;
      endcase
    end
  end

  // compare value pair; the high byte doubles as the pwm shadow
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      duty_low_reg_r <= `CPWM_RST_BYTE;
    else if (wr && (hit(paddr, `CPWM_OFS_CMPV) || hit(paddr, `CPWM_OFS_DUTYL)))
      duty_low_reg_r <= pwdata[7:0];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      duty_shadow_high_r <= `CPWM_RST_BYTE;
      fine_latch_r <= 2'h0;
    end
    else if (is_pwm_mode)
    begin
      // read-only to software here, loaded only at the period end
      if (period_end)
      begin
        duty_shadow_high_r <= duty_low_reg_r;
        fine_latch_r <= module_control_reg_r.fine;
      end
    end
    else if (wr && (hit(paddr, `CPWM_OFS_CMPV) || hit(paddr, `CPWM_OFS_SHADH)))
      duty_shadow_high_r <= hit(paddr, `CPWM_OFS_CMPV) ? pwdata[15:8] : pwdata[7:0];
  end

  // timer one: software write wins, then trigger reset, then count
  assign match = is_cmp_mode && (timer_one_count_r == {duty_shadow_high_r,
    duty_low_reg_r});
  assign cmp_evt = match && !match_d_r && run;
  assign t1_tick = timer_one_tick_i && aux_r[`CPWM_AUX_T1ON] && run;
  assign special_event_o = match && (mode == cpwm_pkg::CPWM_SPECIAL);
  assign adc_start_o = special_event_o && aux_r[`CPWM_AUX_ADCEN];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      match_d_r <= 1'b0;
    else if (run)
      match_d_r <= match;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      timer_one_count_r <= `CPWM_RST_WORD;
    else if (wr && hit(paddr, `CPWM_OFS_T1CNT))
      timer_one_count_r <= pwdata[15:0];
    else if (t1_tick)
    begin
      // match is re-evaluated here, so a moved compare value skips the reset
      if (special_event_o)
        timer_one_count_r <= `CPWM_RST_WORD;
      else
        timer_one_count_r <= timer_one_count_r + 16'h0001;
    end
  end

  // status flags: hardware set beats a same-cycle write-one clear
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      module_irq_flag_r <= 1'b0;
      timer_one_overflow_flag_r <= 1'b0;
    end
    else
    begin
      if (cmp_evt)
        module_irq_flag_r <= 1'b1;
      else if (wr && hit(paddr, `CPWM_OFS_STAT) && pwdata[`CPWM_STAT_IRQ])
        module_irq_flag_r <= 1'b0;
      // only a natural wrap sets overflow, never the trigger reset
      if (t1_tick && !special_event_o && (timer_one_count_r == `CPWM_T1_MAX))
        timer_one_overflow_flag_r <= 1'b1;
      else if (wr && hit(paddr, `CPWM_OFS_STAT) && pwdata[`CPWM_STAT_T1OVF])
        timer_one_overflow_flag_r <= 1'b0;
    end
  end
  assign module_irq_flag_o = module_irq_flag_r;
  // compare output latch
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cmp_latch_r <= 1'b0;
    else if (wr && hit(paddr, `CPWM_OFS_CTRL) && (pwdata[7:0] == `CPWM_RST_BYTE))
      cmp_latch_r <= 1'b0;
    else if (mode == cpwm_pkg::CPWM_OFF)
      cmp_latch_r <= 1'b0;
    else if (cmp_evt)
    begin
      case (mode)
        cpwm_pkg::CPWM_TOGGLE: cmp_latch_r <= !cmp_latch_r;
        cpwm_pkg::CPWM_SET: cmp_latch_r <= 1'b1;
        cpwm_pkg::CPWM_CLEAR: cmp_latch_r <= 1'b0;
        default: cmp_latch_r <= cmp_latch_r;
      endcase
    end
  end

  // timer two: clock phase, instruction-cycle prescaler, 8-bit count
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      phase_r <= 2'h0;
    else if (timer_two_control_r.on && run)
      phase_r <= phase_r + 2'h1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      presc_r <= 4'h0;
    else if (wr && hit(paddr, `CPWM_OFS_T2CNT))
      presc_r <= 4'h0;
    else if (timer_two_control_r.on && run && (phase_r == `CPWM_PH_LAST))
      presc_r <= presc_r + 4'h1;
  end

  // postscaler field is stored only; it never reaches the period logic
  always_comb
  begin
    t2_tick = 1'b0;
    if (timer_two_control_r.on && run && (phase_r == `CPWM_PH_LAST))
    begin
      case (timer_two_control_r.prescale)
        2'h0: t2_tick = 1'b1;
        2'h1: t2_tick = (presc_r[1:0] == `CPWM_PS4_LAST);
        default: t2_tick = (presc_r == `CPWM_PS16_LAST);
      endcase
    end
    case (timer_two_control_r.prescale)
      2'h0: tb_low = phase_r;
      2'h1: tb_low = presc_r[1:0];
      default: tb_low = presc_r[3:2];
    endcase
  end

  assign period_end = t2_tick && (timer_two_count_r == pwm_period_reg_r);
  assign time_base = {timer_two_count_r, tb_low};
  assign duty_act = {duty_shadow_high_r, fine_latch_r};

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      timer_two_count_r <= `CPWM_RST_BYTE;
    else if (wr && hit(paddr, `CPWM_OFS_T2CNT))
      timer_two_count_r <= pwdata[7:0];
    else if (period_end)
      timer_two_count_r <= `CPWM_RST_BYTE;
    else if (t2_tick)
      timer_two_count_r <= timer_two_count_r + 8'h01;
  end

  // pwm output: duty past the period never matches, so the pin stays put
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pwm_out_r <= 1'b0;
    else if (!is_pwm_mode)
      pwm_out_r <= 1'b0;
    else if (period_end)
      pwm_out_r <= ({duty_low_reg_r, module_control_reg_r.fine} != `CPWM_DUTY_ZERO);
    else if (run && (time_base == duty_act))
      pwm_out_r <= 1'b0;
  end

  // pin ownership; soft-interrupt and trigger modes leave the port alone
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      module_pin_owned_o <= 1'b0;
      module_output_pin_o <= 1'b0;
    end
    else
    begin
      module_pin_owned_o <= is_pwm_mode || (mode == cpwm_pkg::CPWM_TOGGLE)
        || (mode == cpwm_pkg::CPWM_SET) || (mode == cpwm_pkg::CPWM_CLEAR);
      module_output_pin_o <= is_pwm_mode ? (pwm_out_r && !(run && (time_base == duty_act)))
        : cmp_latch_r;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_irq_set;
    cmp_evt |=> module_irq_flag_o;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("match did not set flag");

  property p_irq_hold;
    module_irq_flag_o && !(wr && hit(paddr, `CPWM_OFS_STAT)) |=> module_irq_flag_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("flag dropped alone");

  property p_toggle;
    cmp_evt && (mode == cpwm_pkg::CPWM_TOGGLE) && !wr |=> cmp_latch_r != $past(cmp_latch_r);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle failed");

  property p_zero_ctrl;
    wr && hit(paddr, `CPWM_OFS_CTRL) && (pwdata[7:0] == 8'h00) |=> !cmp_latch_r ##1
      !module_pin_owned_o && !module_output_pin_o;
  endproperty
  a_zero_ctrl: assert property (p_zero_ctrl) else $error("clear did not release pin");

  property p_no_pin;
    (mode == cpwm_pkg::CPWM_SOFTIRQ) || (mode == cpwm_pkg::CPWM_SPECIAL) |=> !module_pin_owned_o;
  endproperty
  a_no_pin: assert property (p_no_pin) else $error("pin owned in event mode");

  property p_trig_reset;
    special_event_o && t1_tick && !wr |=> timer_one_count_r == 16'h0000;
  endproperty
  a_trig_reset: assert property (p_trig_reset) else $error("trigger did not clear timer");

  property p_trig_match;
    t1_tick && !special_event_o && !wr
      |=> timer_one_count_r == $past(timer_one_count_r) + 16'h0001;
  endproperty
  a_trig_match: assert property (p_trig_match) else $error("count reset without match");

  property p_no_ovf;
    $rose(timer_one_overflow_flag_r) |-> $past(timer_one_count_r) == 16'hFFFF
      && !$past(special_event_o);
  endproperty
  a_no_ovf: assert property (p_no_ovf) else $error("overflow set by trigger");

  property p_pwm_start;
    is_pwm_mode && period_end && ({duty_low_reg_r, module_control_reg_r.fine} != 10'h000) && !wr
      |=> pwm_out_r ##1 module_output_pin_o;
  endproperty
  a_pwm_start: assert property (p_pwm_start) else $error("period start not high");

  property p_pwm_stop;
    is_pwm_mode && !period_end && run && (time_base == duty_act) |=> !pwm_out_r;
  endproperty
  a_pwm_stop: assert property (p_pwm_stop) else $error("duty match not low");

  property p_shadow;
    is_pwm_mode && !period_end |=> $stable(duty_shadow_high_r);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow moved mid period");

  property p_sleep;
    sleep_i && !wr |=> $stable(timer_two_count_r) && $stable(pwm_out_r);
  endproperty
  a_sleep: assert property (p_sleep) else $error("state moved in sleep");

  c_trig: cover property (special_event_o && t1_tick);
  c_pwm: cover property (is_pwm_mode && period_end ##[1:300] !pwm_out_r);
  c_toggle: cover property (cmp_evt && mode == cpwm_pkg::CPWM_TOGGLE);
endmodule
`default_nettype wire

// ===== verification/cpwm_load_model.sv
// external load on the module pin, measures pwm period and high time
`timescale 1ns/1ps
`default_nettype none

module cpwm_load_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  input wire logic oe_i,
  output logic level_o,
  output logic [15:0] rises_o,
  output logic [15:0] period_o,
  output logic [15:0] high_o
);
  logic [15:0] cnt_r;
  logic [15:0] hcnt_r;
  logic last_r;

  // driver enabled only while the unit owns the pin; weak pull-down otherwise
  assign level_o = oe_i ? pin_i : 1'b0;

  // counts from rise to rise, so a stuck pin never updates the figures
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= 16'h0;
      hcnt_r <= 16'h0;
      last_r <= 1'b0;
      rises_o <= 16'h0;
      period_o <= 16'h0;
      high_o <= 16'h0;
    end
    else
    begin
      last_r <= level_o;
      if (level_o && !last_r)
      begin
        period_o <= cnt_r;
        high_o <= hcnt_r;
        cnt_r <= 16'h1;
        hcnt_r <= 16'h1;
        rises_o <= rises_o + 16'h1;
      end
      else
      begin
        cnt_r <= cnt_r + 16'h1;
        hcnt_r <= hcnt_r + {15'h0, level_o};
      end
    end
  end
endmodule

`default_nettype wire

// ===== verification/compare_and_pwm_unit_test.sv
// self-checking bench for the compare/pwm unit
`timescale 1ns/1ps
`default_nettype none
`include "cpwm_consts.svh"

module compare_and_pwm_unit_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tick = 1'b0;
  logic sleep = 1'b0;
  logic pin;
  logic owned;
  logic irq;
  logic sev;
  logic adc;
  logic level;
  logic lv;
  logic [15:0] rises;
  logic [15:0] per;
  logic [15:0] hi;
  logic [15:0] snap;
  logic [31:0] rdata;
  logic rerr;
  int err_total = 0;
  int checks = 0;
  cpwm_pkg::cpwm_mode_t modes [4] = '{cpwm_pkg::CPWM_SET, cpwm_pkg::CPWM_CLEAR,
    cpwm_pkg::CPWM_TOGGLE, cpwm_pkg::CPWM_SOFTIRQ};
  logic [3:0] own_exp = 4'h7;
  logic [3:0] pin_exp = 4'h5;

  always #4 clk_i = ~clk_i;

  cpwm_unit u_dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .timer_one_tick_i(tick),
    .sleep_i(sleep),
    .module_output_pin_o(pin),
    .module_pin_owned_o(owned),
    .module_irq_flag_o(irq),
    .special_event_o(sev),
    .adc_start_o(adc)
  );

  cpwm_load_model u_load (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(pin),
    .oe_i(owned),
    .level_o(level),
    .rises_o(rises),
    .period_o(per),
    .high_o(hi)
  );

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1)
      @(posedge clk_i);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // one-cycle enable pulses with a gap, as a synchronous timer clock
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
    end
    #1;
  endtask

  task automatic wait_rises(input int n);
    logic [15:0] r0;
    int k;
    r0 = rises;
    k = 0;
    while (rises < r0 + n && k < 9000)
    begin
      @(posedge clk_i);
      k++;
    end
    chk_bit(k < 9000, 1'b1);
  endtask

  task automatic final_report;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    final_report();
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`CPWM_OFS_PERIOD);
    chk_val(rdata, 32'hFF);
    rd(8'h30);
    chk_bit(rerr, 1'b1);
    chk_val(rdata, 32'h0);
    // high byte equals the count start's, so only the low byte counts up to the match
    wr(`CPWM_OFS_AUX, 32'h3);
    wr(`CPWM_OFS_CMPV, 32'h1205);
    for (int i = 0; i < 4; i++)
    begin
      wr(`CPWM_OFS_STAT, 32'h1);
      wr(`CPWM_OFS_T1CNT, 32'h1200);
      wr(`CPWM_OFS_CTRL, {28'h0, modes[i]});
      ticks(8);
      settle(3);
      chk_bit(irq, 1'b1);
      chk_bit(owned, own_exp[i]);
      if (own_exp[i])
        chk_bit(pin, pin_exp[i]);
    end
    settle(20);
    chk_bit(irq, 1'b1);
    wr(`CPWM_OFS_STAT, 32'h1);
    settle(2);
    chk_bit(irq, 1'b0);
    wr(`CPWM_OFS_CTRL, 32'h0);
    settle(2);
    chk_bit(owned, 1'b0);
    wr(`CPWM_OFS_CTRL, {28'h0, cpwm_pkg::CPWM_TOGGLE});
    settle(2);
    chk_bit(pin, 1'b0);
    wr(`CPWM_OFS_CMPV, 32'h5);
    wr(`CPWM_OFS_T1CNT, 32'h0);
    wr(`CPWM_OFS_CTRL, {28'h0, cpwm_pkg::CPWM_SPECIAL});
    ticks(5);
    chk_bit(sev, 1'b1);
    chk_bit(adc, 1'b1);
    chk_bit(owned, 1'b0);
    ticks(3);
    rd(`CPWM_OFS_T1CNT);
    chk_val(rdata, 32'h2);
    rd(`CPWM_OFS_STAT);
    chk_val(rdata, 32'h1);
    wr(`CPWM_OFS_T1CNT, 32'h0);
    ticks(5);
    wr(`CPWM_OFS_CMPV, 32'h6);
    ticks(1);
    rd(`CPWM_OFS_T1CNT);
    chk_val(rdata, 32'h6);
    wr(`CPWM_OFS_AUX, 32'h1);
    settle(1);
    chk_bit(adc, 1'b0);
    // pwm at period 3, duty 8 quarter steps, postscale set but unused
    wr(`CPWM_OFS_CTRL, 32'h0);
    wr(`CPWM_OFS_PERIOD, 32'h3);
    wr(`CPWM_OFS_DUTYL, 32'h2);
    wr(`CPWM_OFS_CTRL, 32'hC);
    wr(`CPWM_OFS_T2CTL, 32'h7C);
    wait_rises(3);
    chk_val({16'h0, per}, 32'h10);
    chk_val({16'h0, hi}, 32'h8);
    rd(`CPWM_OFS_SHADH);
    chk_val(rdata, 32'h2);
    wr(`CPWM_OFS_SHADH, 32'h55);
    rd(`CPWM_OFS_SHADH);
    chk_val(rdata, 32'h2);
    wr(`CPWM_OFS_DUTYL, 32'h1);
    wr(`CPWM_OFS_CTRL, 32'h3C);
    wait_rises(3);
    chk_val({16'h0, hi}, 32'h7);
    wr(`CPWM_OFS_T2CTL, 32'h5);
    wait_rises(3);
    chk_val({16'h0, per}, 32'h40);
    chk_val({16'h0, hi}, 32'h1C);
    wr(`CPWM_OFS_T2CTL, 32'h6);
    wait_rises(3);
    chk_val({16'h0, per}, 32'h100);
    chk_val({16'h0, hi}, 32'h70);
    wr(`CPWM_OFS_PERIOD, 32'hFF);
    wr(`CPWM_OFS_DUTYL, 32'hFF);
    wr(`CPWM_OFS_T2CTL, 32'h4);
    wait_rises(3);
    chk_val({16'h0, per}, 32'h400);
    chk_val({16'h0, hi}, 32'h3FF);
    // timer two may sit above the new period, so allow a full wrap
    wr(`CPWM_OFS_PERIOD, 32'h3);
    wr(`CPWM_OFS_DUTYL, 32'h0);
    wr(`CPWM_OFS_CTRL, 32'hC);
    settle(1100);
    snap = rises;
    settle(40);
    chk_val({16'h0, rises}, {16'h0, snap});
    chk_bit(level, 1'b0);
    wr(`CPWM_OFS_DUTYL, 32'h10);
    settle(40);
    snap = rises;
    settle(40);
    chk_val({16'h0, rises}, {16'h0, snap});
    chk_bit(level, 1'b1);
    wr(`CPWM_OFS_DUTYL, 32'h2);
    settle(40);
    @(posedge clk_i);
    sleep <= 1'b1;
    rd(`CPWM_OFS_T2CNT);
    snap = rdata[15:0];
    lv = level;
    settle(37);
    rd(`CPWM_OFS_T2CNT);
    chk_val(rdata, {16'h0, snap});
    chk_bit(level, lv);
    sleep <= 1'b0;
    wait_rises(2);
    chk_val({16'h0, per}, 32'h10);
    wr(`CPWM_OFS_CTRL, 32'h0);
    settle(2);
    chk_bit(owned, 1'b0);
    chk_bit(level, 1'b0);
    final_report();
  end
endmodule

`default_nettype wire
